// *** hdl/autoneg_gigabit_pkg.sv ***
// Register indices, field positions and reset values of the autonegotiation bank
package autoneg_gigabit_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PARTNER_BASE = 10'h005;
    localparam logic [IDX_W-1:0] IDX_EXPANSION = 10'h006;
    localparam logic [IDX_W-1:0] IDX_NP_TRANSMIT = 10'h007;
    localparam logic [IDX_W-1:0] IDX_PARTNER_NP = 10'h008;
    localparam logic [IDX_W-1:0] IDX_GIG_CONTROL = 10'h009;
    localparam logic [IDX_W-1:0] IDX_GIG_STATUS = 10'h00a;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 10'h010;
    localparam logic [IDX_W-1:0] IDX_INT_MASK = 10'h011;
    // Reset values, writable mask and limits
    localparam logic [15:0] PARTNER_RST = 16'h0000;
    localparam logic [15:0] NP_TRANSMIT_RST = 16'h2001;
    localparam logic [15:0] NP_TRANSMIT_WMASK = 16'hb7ff;
    localparam logic [15:0] GIG_CONTROL_RST = 16'h0700;
    localparam logic [7:0] IDLE_RST = 8'h00;
    localparam logic [7:0] IDLE_MAX = 8'hff;
    localparam logic [2:0] TEST_MODE_MAX = 3'h4;
    localparam logic [2:0] TEST_MODE_NORMAL = 3'h0;
    // Expansion fields
    localparam int EXP_PD_FAULT = 4;
    localparam int EXP_PARTNER_NP = 3;
    localparam int EXP_LOCAL_NP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_PARTNER_AN = 0;
    // Next page transmit fields
    localparam int NPT_MORE = 15;
    localparam int NPT_MESSAGE = 13;
    localparam int NPT_ACK2 = 12;
    localparam int NPT_TOGGLE = 11;
    // Gigabit control fields
    localparam int GC_TEST_HI = 15;
    localparam int GC_TEST_LO = 13;
    localparam int GC_MS_MANUAL = 12;
    localparam int GC_MS_MASTER = 11;
    localparam int GC_PORT_TYPE = 10;
    localparam int GC_ADV_FDX = 9;
    localparam int GC_ADV_HDX = 8;
    // Gigabit status fields
    localparam int GS_MS_FAULT = 15;
    localparam int GS_MS_MASTER = 14;
    localparam int GS_LOCAL_RX = 13;
    localparam int GS_REMOTE_RX = 12;
    localparam int GS_PARTNER_FDX = 11;
    localparam int GS_PARTNER_HDX = 10;
    // Interrupt status and mask fields
    localparam int INT_W = 4;
    localparam int INT_PAGE = 0;
    localparam int INT_PD_FAULT = 1;
    localparam int INT_MS_FAULT = 2;
    localparam int INT_IDLE_SAT = 3;
    localparam logic [INT_W-1:0] INT_RST = 4'h0;
endpackage

// *** hdl/autoneg_gigabit_status_regs.sv ***
// Autonegotiation and gigabit control/status register bank behind an APB slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module autoneg_gigabit_status_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic [autoneg_gigabit_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Negotiation engine, partner side
    input wire logic [15:0] partnerAbility,
    input wire logic basePageStrobe,
    input wire logic [15:0] partnerNextPage,
    input wire logic nextPageStrobe,
    input wire logic pageRecvLive,
    input wire logic parallelDetectFault,
    input wire logic partnerNpCapable,
    input wire logic partnerAnCapable,
    input wire logic lastCodewordToggle,
    // Gigabit engine status
    input wire logic msConfigFault,
    input wire logic msResolvedMaster,
    input wire logic localRxOk,
    input wire logic remoteRxOk,
    input wire logic partnerGigFullDuplex,
    input wire logic partnerGigHalfDuplex,
    input wire logic idleError,
    // Controls to the engine
    output logic [2:0] testModeSel,
    output logic msManualEnable,
    output logic msForceMaster,
    output logic multiPort,
    output logic advGigFullDuplex,
    output logic advGigHalfDuplex,
    output logic [15:0] nextPageWord,
    // Interrupt
    output logic irq
);
    import autoneg_gigabit_pkg::*;

    logic [15:0] baseAbility_r;
    logic [15:0] partnerNp_r;
    logic [15:0] npTransmit_r;
    logic [15:0] gigControl_r;
    logic pdFaultLatch_r;
    logic pageRxLatch_r;
    logic msFaultLatch_r;
    logic partnerNpCap_r;
    logic partnerAnCap_r;
    logic toggle_r;
    logic msMaster_r;
    logic localRx_r;
    logic remoteRx_r;
    logic partnerFdx_r;
    logic partnerHdx_r;
    logic [7:0] idleCount_r;
    logic [INT_W-1:0] intStatus_r;
    logic [INT_W-1:0] intMask_r;
    logic [INT_W-1:0] intEvents;
    logic [IDX_W-1:0] regIdx;
    logic setupRd;
    logic accessWr;
    logic [15:0] wrMask;
    logic [15:0] rdValue;
    logic rdHit;

    assign regIdx = paddr[ADDR_W-1:2];
    // Read side effects happen at the setup edge, where read data is captured
    assign setupRd = psel && !penable && !pwrite;
    assign accessWr = psel && penable && pwrite;
    assign wrMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign pready = 1'b1;

    // Captured partner pages
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            baseAbility_r <= PARTNER_RST;
            partnerNp_r <= PARTNER_RST;
        end else begin
            if (basePageStrobe) begin
                baseAbility_r <= partnerAbility;
            end
            if (nextPageStrobe) begin
                partnerNp_r <= partnerNextPage;
            end
        end
    end

    // Live status samples
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            partnerNpCap_r <= 1'b0;
            partnerAnCap_r <= 1'b0;
            toggle_r <= 1'b0;
            msMaster_r <= 1'b1;
            localRx_r <= 1'b0;
            remoteRx_r <= 1'b0;
            partnerFdx_r <= 1'b0;
            partnerHdx_r <= 1'b0;
        end else begin
            partnerNpCap_r <= partnerNpCapable;
            partnerAnCap_r <= partnerAnCapable;
            toggle_r <= !lastCodewordToggle;
            msMaster_r <= msResolvedMaster;
            localRx_r <= localRxOk;
            remoteRx_r <= remoteRxOk;
            partnerFdx_r <= partnerGigFullDuplex;
            partnerHdx_r <= partnerGigHalfDuplex;
        end
    end

    // Latched bits; an event in the read cycle wins over the reload
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pdFaultLatch_r <= 1'b0;
            pageRxLatch_r <= 1'b0;
            msFaultLatch_r <= 1'b0;
        end else begin
            if (parallelDetectFault) begin
                pdFaultLatch_r <= 1'b1;
            end else if (setupRd && regIdx == IDX_EXPANSION) begin
                pdFaultLatch_r <= 1'b0;
            end
            if (!pageRecvLive) begin
                pageRxLatch_r <= 1'b0;
            end else if (setupRd && regIdx == IDX_EXPANSION) begin
                pageRxLatch_r <= 1'b1;
            end
            if (msConfigFault) begin
                msFaultLatch_r <= 1'b1;
            end else if (setupRd && regIdx == IDX_GIG_STATUS) begin
                msFaultLatch_r <= 1'b0;
            end
        end
    end

    // Idle error counter, saturating
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idleCount_r <= IDLE_RST;
        end else if (setupRd && regIdx == IDX_GIG_STATUS) begin
            idleCount_r <= idleError ? 8'h01 : IDLE_RST;
        end else if (idleError && idleCount_r != IDLE_MAX) begin
            idleCount_r <= idleCount_r + 8'h01;
        end
    end

    // Writable registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            npTransmit_r <= NP_TRANSMIT_RST;
            gigControl_r <= GIG_CONTROL_RST;
            intMask_r <= INT_RST;
        end else if (accessWr) begin
            if (regIdx == IDX_NP_TRANSMIT) begin
                npTransmit_r <= (npTransmit_r & ~(wrMask & NP_TRANSMIT_WMASK))
                    | (pwdata[15:0] & wrMask & NP_TRANSMIT_WMASK);
            end else if (regIdx == IDX_GIG_CONTROL) begin
                gigControl_r <= (gigControl_r & ~wrMask) | (pwdata[15:0] & wrMask);
            end else if (regIdx == IDX_INT_MASK && pstrb[0]) begin
                intMask_r <= pwdata[INT_W-1:0];
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    assign intEvents[INT_PAGE] = nextPageStrobe || basePageStrobe;
    assign intEvents[INT_PD_FAULT] = parallelDetectFault;
    assign intEvents[INT_MS_FAULT] = msConfigFault;
    assign intEvents[INT_IDLE_SAT] = idleError && idleCount_r == IDLE_MAX;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            intStatus_r <= INT_RST;
        end else begin
            intStatus_r <= (intStatus_r & ~((accessWr && regIdx == IDX_INT_STATUS
                && pstrb[0]) ? pwdata[INT_W-1:0] : INT_RST)) | intEvents;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStatus_r & intMask_r);
        end
    end

    // Read multiplexer
    always_comb begin
        rdValue = 16'h0000;
        rdHit = 1'b1;
        if (regIdx == IDX_PARTNER_BASE) begin
            rdValue = baseAbility_r;
        end else if (regIdx == IDX_EXPANSION) begin
            rdValue[EXP_PD_FAULT] = pdFaultLatch_r;
            rdValue[EXP_PARTNER_NP] = partnerNpCap_r;
            rdValue[EXP_LOCAL_NP] = 1'b1;
            rdValue[EXP_PAGE_RX] = pageRxLatch_r;
            rdValue[EXP_PARTNER_AN] = partnerAnCap_r;
        end else if (regIdx == IDX_NP_TRANSMIT) begin
            rdValue = npTransmit_r;
            rdValue[NPT_TOGGLE] = toggle_r;
        end else if (regIdx == IDX_PARTNER_NP) begin
            rdValue = partnerNp_r;
        end else if (regIdx == IDX_GIG_CONTROL) begin
            rdValue = gigControl_r;
        end else if (regIdx == IDX_GIG_STATUS) begin
            rdValue[GS_MS_FAULT] = msFaultLatch_r;
            rdValue[GS_MS_MASTER] = msMaster_r;
            rdValue[GS_LOCAL_RX] = localRx_r;
            rdValue[GS_REMOTE_RX] = remoteRx_r;
            rdValue[GS_PARTNER_FDX] = partnerFdx_r;
            rdValue[GS_PARTNER_HDX] = partnerHdx_r;
            rdValue[7:0] = idleCount_r;
        end else if (regIdx == IDX_INT_STATUS) begin
            rdValue[INT_W-1:0] = intStatus_r;
        end else if (regIdx == IDX_INT_MASK) begin
            rdValue[INT_W-1:0] = intMask_r;
        end else begin
            rdHit = 1'b0;
        end
    end

    // Read data and error are captured at setup and held through access
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rdValue};
            pslverr <= !rdHit;
        end
    end

    // Engine controls
    always_comb begin
        testModeSel = gigControl_r[GC_TEST_HI:GC_TEST_LO];
        if (testModeSel > TEST_MODE_MAX) begin
            testModeSel = TEST_MODE_NORMAL;
        end
    end
    assign msManualEnable = gigControl_r[GC_MS_MANUAL];
    assign msForceMaster = gigControl_r[GC_MS_MANUAL] && gigControl_r[GC_MS_MASTER];
    assign multiPort = gigControl_r[GC_PORT_TYPE];
    assign advGigFullDuplex = gigControl_r[GC_ADV_FDX];
    assign advGigHalfDuplex = gigControl_r[GC_ADV_HDX];
    assign nextPageWord = {npTransmit_r[15:12], toggle_r, npTransmit_r[10:0]};

    // Checks
    property p_pd_latch;
        @(posedge sys_clk) disable iff (!reset_n)
        parallelDetectFault |=> pdFaultLatch_r
            ##1 (pdFaultLatch_r || $past(setupRd && regIdx == IDX_EXPANSION));
    endproperty
    a_pd_latch: assert property (p_pd_latch) else $error("pd fault not latched");

    property p_page_low;
        @(posedge sys_clk) disable iff (!reset_n)
        !pageRecvLive |=> !pageRxLatch_r;
    endproperty
    a_page_low: assert property (p_page_low) else $error("page bit not low");

    property p_local_np;
        @(posedge sys_clk) disable iff (!reset_n)
        setupRd && regIdx == IDX_EXPANSION |=> prdata[EXP_LOCAL_NP] && !pslverr;
    endproperty
    a_local_np: assert property (p_local_np) else $error("local np bit low");

    property p_base_read;
        @(posedge sys_clk) disable iff (!reset_n)
        setupRd && regIdx == IDX_PARTNER_BASE |=> prdata[15:0] == $past(baseAbility_r);
    endproperty
    a_base_read: assert property (p_base_read) else $error("base ability wrong");

    property p_toggle;
        @(posedge sys_clk) disable iff (!reset_n)
        setupRd && regIdx == IDX_NP_TRANSMIT ##1 1'b1
            |-> prdata[NPT_TOGGLE] == !$past(lastCodewordToggle, 2);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not inverted");

    property p_test_mode;
        @(posedge sys_clk) disable iff (!reset_n)
        testModeSel <= TEST_MODE_MAX;
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("reserved test mode");

    property p_ms_force;
        @(posedge sys_clk) disable iff (!reset_n)
        accessWr && regIdx == IDX_GIG_CONTROL && pstrb[1]
            |=> msForceMaster == ($past(pwdata[GC_MS_MANUAL]) && $past(pwdata[GC_MS_MASTER]));
    endproperty
    a_ms_force: assert property (p_ms_force) else $error("force master wrong");

    property p_ms_latch;
        @(posedge sys_clk) disable iff (!reset_n)
        msConfigFault |=> msFaultLatch_r;
    endproperty
    a_ms_latch: assert property (p_ms_latch) else $error("ms fault not latched");

    property p_idle_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        setupRd && regIdx == IDX_GIG_STATUS && !idleError
            |=> idleCount_r == IDLE_RST && prdata[7:0] == $past(idleCount_r);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle count not cleared");

    property p_base_capture;
        @(posedge sys_clk) disable iff (!reset_n)
        basePageStrobe |=> baseAbility_r == $past(partnerAbility);
    endproperty
    a_base_capture: assert property (p_base_capture) else $error("base page not captured");

    property p_partner_cap;
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> {partnerNpCap_r, partnerAnCap_r} == $past({partnerNpCapable, partnerAnCapable});
    endproperty
    a_partner_cap: assert property (p_partner_cap) else $error("partner capability stale");

    property p_np_write;
        @(posedge sys_clk) disable iff (!reset_n)
        accessWr && regIdx == IDX_NP_TRANSMIT && pstrb[1] |=> npTransmit_r[NPT_MORE]
            == $past(pwdata[NPT_MORE]) && npTransmit_r[NPT_MESSAGE] == $past(pwdata[NPT_MESSAGE]);
    endproperty
    a_np_write: assert property (p_np_write) else $error("next page flags not written");

    property p_ack2_write;
        @(posedge sys_clk) disable iff (!reset_n)
        accessWr && regIdx == IDX_NP_TRANSMIT && pstrb[1]
            |=> npTransmit_r[NPT_ACK2] == $past(pwdata[NPT_ACK2]);
    endproperty
    a_ack2_write: assert property (p_ack2_write) else $error("ack2 bit not written");

    property p_np_capture;
        @(posedge sys_clk) disable iff (!reset_n)
        nextPageStrobe |=> partnerNp_r == $past(partnerNextPage);
    endproperty
    a_np_capture: assert property (p_np_capture) else $error("next page not captured");

    property p_test_pass;
        @(posedge sys_clk) disable iff (!reset_n)
        gigControl_r[GC_TEST_HI:GC_TEST_LO] <= TEST_MODE_MAX
            |-> testModeSel == gigControl_r[GC_TEST_HI:GC_TEST_LO];
    endproperty
    a_test_pass: assert property (p_test_pass) else $error("test mode not passed on");

    property p_resolution;
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> msMaster_r == $past(msResolvedMaster);
    endproperty
    a_resolution: assert property (p_resolution) else $error("resolution bit stale");

    property p_rx_status;
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> {localRx_r, remoteRx_r} == $past({localRxOk, remoteRxOk});
    endproperty
    a_rx_status: assert property (p_rx_status) else $error("receiver status stale");

    property p_partner_gig;
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> {partnerFdx_r, partnerHdx_r}
            == $past({partnerGigFullDuplex, partnerGigHalfDuplex});
    endproperty
    a_partner_gig: assert property (p_partner_gig) else $error("partner gigabit stale");
endmodule

// *** bench/link_partner_model.sv ***
// Far-side negotiation engine model that drives the page, event and level inputs
`timescale 1ns/1ps
module link_partner_model (
    // Clock
    input wire logic sys_clk,
    // Received pages
    output logic [15:0] partnerAbility,
    output logic basePageStrobe,
    output logic [15:0] partnerNextPage,
    output logic nextPageStrobe,
    // Negotiation levels and events
    output logic pageRecvLive,
    output logic parallelDetectFault,
    output logic partnerNpCapable,
    output logic partnerAnCapable,
    output logic lastCodewordToggle,
    // Gigabit engine
    output logic msConfigFault,
    output logic msResolvedMaster,
    output logic localRxOk,
    output logic remoteRxOk,
    output logic partnerGigFullDuplex,
    output logic partnerGigHalfDuplex,
    output logic idleError
);
    logic [8:0] lvl;

    assign {pageRecvLive, partnerNpCapable, partnerAnCapable, lastCodewordToggle} = lvl[8:5];
    assign {msResolvedMaster, localRxOk, remoteRxOk} = lvl[4:2];
    assign {partnerGigFullDuplex, partnerGigHalfDuplex} = lvl[1:0];

    initial begin
        lvl = 9'h030;
        {partnerAbility, partnerNextPage} = 32'h0;
        {basePageStrobe, nextPageStrobe, parallelDetectFault} = 3'h0;
        {msConfigFault, idleError} = 2'h0;
    end

    // Page data is valid only with its strobe; afterwards the lines carry garbage
    task automatic sendPage(input logic np, input logic [15:0] d);
        @(posedge sys_clk);
        partnerNextPage <= np ? d : ~partnerNextPage;
        partnerAbility <= np ? ~partnerAbility : d;
        nextPageStrobe <= np;
        basePageStrobe <= ~np;
        @(posedge sys_clk);
        partnerNextPage <= ~d;
        partnerAbility <= ~d;
        {nextPageStrobe, basePageStrobe} <= 2'h0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic setLevels(input logic [8:0] v);
        @(posedge sys_clk);
        lvl <= v;
        repeat (2) @(posedge sys_clk);
    endtask

    // One-cycle event: 0 parallel detect fault, 1 master/slave fault, 2 idle error
    task automatic pulseEvent(input int which);
        @(posedge sys_clk);
        {idleError, msConfigFault, parallelDetectFault} <= 3'h1 << which;
        @(posedge sys_clk);
        {idleError, msConfigFault, parallelDetectFault} <= 3'h0;
    endtask
endmodule

// *** bench/tb_autoneg_gigabit_status_regs.sv ***
// Self-checking bench for the autonegotiation and gigabit register bank
`timescale 1ns/1ps
module tb_autoneg_gigabit_status_regs;
    import autoneg_gigabit_pkg::*;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] pAb, pNp, npWord, v, w;
    logic bStb, nStb, live, pdF, npCap, anCap, tog, msF, msM, lRx, rRx, gF, gH, idl;
    logic [2:0] tMode;
    logic msMan, msFrc, mPort, aF, aH, err;
    logic [8:0] lv;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 1125;
    int n;

    autoneg_gigabit_status_regs u_autoneg_gigabit_status_regs (
        .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .partnerAbility(pAb), .basePageStrobe(bStb), .partnerNextPage(pNp),
        .nextPageStrobe(nStb), .pageRecvLive(live), .parallelDetectFault(pdF),
        .partnerNpCapable(npCap), .partnerAnCapable(anCap), .lastCodewordToggle(tog),
        .msConfigFault(msF), .msResolvedMaster(msM), .localRxOk(lRx), .remoteRxOk(rRx),
        .partnerGigFullDuplex(gF), .partnerGigHalfDuplex(gH), .idleError(idl),
        .testModeSel(tMode), .msManualEnable(msMan), .msForceMaster(msFrc),
        .multiPort(mPort), .advGigFullDuplex(aF), .advGigHalfDuplex(aH),
        .nextPageWord(npWord), .irq(irq));

    link_partner_model u_link_partner_model (
        .sys_clk(sys_clk), .partnerAbility(pAb), .basePageStrobe(bStb),
        .partnerNextPage(pNp), .nextPageStrobe(nStb), .pageRecvLive(live),
        .parallelDetectFault(pdF), .partnerNpCapable(npCap), .partnerAnCapable(anCap),
        .lastCodewordToggle(tog), .msConfigFault(msF), .msResolvedMaster(msM),
        .localRxOk(lRx), .remoteRxOk(rRx), .partnerGigFullDuplex(gF),
        .partnerGigHalfDuplex(gH), .idleError(idl));

    always #5 sys_clk = ~sys_clk;

    function automatic logic [15:0] expNp(input logic [15:0] d, input logic t);
        return (d & NP_TRANSMIT_WMASK) | {4'h0, ~t, 11'h0};
    endfunction

    function automatic logic [15:0] expExp(input logic [8:0] l, input logic pd, input logic pg);
        return {11'h0, pd, l[7], 1'b1, pg, l[6]};
    endfunction

    function automatic logic [15:0] expGs(input logic [8:0] l, input logic f, input int c);
        return {f, l[4:0], 2'b00, 8'(c)};
    endfunction

    function automatic logic [7:0] expCtl(input logic [15:0] d);
        return {(d[15:13] > 3'h4) ? 3'h0 : d[15:13], d[12], d[12] & d[11], d[10:8]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {16'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [9:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0);
        check(rd, {16'h0, exp});
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        results();
    end

    initial begin
        {sys_clk, reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'h3;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdChk(IDX_PARTNER_BASE, 16'h0000);
        rdChk(IDX_EXPANSION, 16'h0004);
        rdChk(IDX_NP_TRANSMIT, 16'h2001);
        check(npWord, NP_TRANSMIT_RST);
        rdChk(IDX_PARTNER_NP, 16'h0000);
        rdChk(IDX_GIG_CONTROL, 16'h0700);
        rdChk(IDX_GIG_STATUS, 16'h4000);
        // Interrupt on page arrival, masked, then cleared; base page is read-only
        apb(1'b1, IDX_INT_MASK, 16'h0001);
        v = 16'($random(seed));
        u_link_partner_model.sendPage(1'b0, v);
        check(irq, 1'b1);
        apb(1'b1, IDX_PARTNER_BASE, ~v);
        rdChk(IDX_PARTNER_BASE, v);
        apb(1'b1, IDX_INT_MASK, 16'h0000);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        apb(1'b1, IDX_INT_MASK, 16'h0001);
        rdChk(IDX_INT_STATUS, 16'h0001);
        apb(1'b1, IDX_INT_STATUS, 16'h0001);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        apb(1'b0, 10'h3ff, 16'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            u_link_partner_model.sendPage(1'b1, v);
            rdChk(IDX_PARTNER_NP, v);
            lv = 9'($random(seed));
            lv[8] = 1'b0;
            u_link_partner_model.setLevels(lv);
            rdChk(IDX_EXPANSION, expExp(lv, 1'b0, 1'b0));
            lv[8] = 1'b1;
            u_link_partner_model.setLevels(lv);
            rdChk(IDX_EXPANSION, expExp(lv, 1'b0, 1'b0));
            rdChk(IDX_EXPANSION, expExp(lv, 1'b0, 1'b1));
            rdChk(IDX_GIG_STATUS, expGs(lv, 1'b0, 0));
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
            apb(1'b1, IDX_NP_TRANSMIT, w);
            rdChk(IDX_NP_TRANSMIT, expNp(w, lv[5]));
            check(npWord, expNp(w, lv[5]));
        end
        u_link_partner_model.pulseEvent(0);
        rdChk(IDX_EXPANSION, expExp(lv, 1'b1, 1'b1));
        rdChk(IDX_EXPANSION, expExp(lv, 1'b0, 1'b1));
        u_link_partner_model.pulseEvent(1);
        rdChk(IDX_GIG_STATUS, expGs(lv, 1'b1, 0));
        rdChk(IDX_GIG_STATUS, expGs(lv, 1'b0, 0));
        n = 1 + ($random(seed) & 15);
        repeat (n) u_link_partner_model.pulseEvent(2);
        repeat (2) @(posedge sys_clk);
        rdChk(IDX_GIG_STATUS, expGs(lv, 1'b0, n));
        rdChk(IDX_GIG_STATUS, expGs(lv, 1'b0, 0));
        for (int c = 0; c < 8; c++) begin
            w = {3'(c), 13'($random(seed))};
            // No media sensing on this bench, so test codes may be written
            apb(1'b1, IDX_GIG_CONTROL, w);
            rdChk(IDX_GIG_CONTROL, w);
            check({tMode, msMan, msFrc, mPort, aF, aH}, expCtl(w));
        end
        results();
    end
endmodule
